// File: light_flag_regs.svh
`ifndef LIGHT_FLAG_REGS_SVH
`define LIGHT_FLAG_REGS_SVH

// register offsets on the software port
`define OFS_RESULT 8'h00
`define OFS_CONFIG 8'h01
`define OFS_LOW_LIMIT 8'h02
`define OFS_HIGH_LIMIT 8'h03
`define OFS_IRQ_STATUS 8'h04
`define OFS_IRQ_MASK 8'h05

// exponent and mantissa layout of result and limit words
`define EXP_MSB 15
`define EXP_LSB 12
`define MANT_MSB 11
`define MANT_LSB 0

// sticky event bits of the status and mask registers
`define IRQ_DONE_BIT 0
`define IRQ_ABOVE_BIT 1
`define IRQ_BELOW_BIT 2

// reset values
`define RST_RANGE 4'h0
`define RST_CONV_TIME 1'h1
`define RST_LATCH 1'h1
`define RST_LOW_LIMIT 16'h0000
`define RST_HIGH_LIMIT 16'hFFFF
`define RST_IRQ_MASK 3'h0

// automatic ranging code; lower codes are manual ranges
`define RANGE_AUTO 4'hC

// consecutive-fault targets for each fault count code
`define FAULTS_CODE0 4'h1
`define FAULTS_CODE1 4'h2
`define FAULTS_CODE2 4'h4
`define FAULTS_CODE3 4'h8

`endif

// File: light_flag_pkg.sv
`default_nettype none

package light_flag_pkg;

  // conversion mode codes
  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_CONT_A = 2'h2,
    MODE_CONT_B = 2'h3
  } conv_mode_t;

  // configuration word, bit 15 first
  typedef struct packed {
    logic [3:0] range_select;
    logic conv_time;
    conv_mode_t mode;
    logic overflow;
    logic conversion_done_flag;
    logic above_limit_flag;
    logic below_limit_flag;
    logic latch_sel;
    logic irq_polarity;
    logic exponent_mask_enable;
    logic [1:0] fault_count_select;
  } cfg_t;

  // one finished conversion from the converter
  typedef struct packed {
    logic done;
    logic overflow;
    logic [15:0] result;
  } conv_t;

endpackage : light_flag_pkg

`default_nettype wire

// File: light_threshold_flag_logic.sv
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "light_flag_regs.svh"
`default_nettype none

module light_threshold_flag_logic (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // register port
  input wire logic [7:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WE_I,
  input wire logic RE_I,
  output logic [15:0] RDATA_O,
  // converter side
  input wire light_flag_pkg::conv_t CONV_I,
  output logic [1:0] MODE_O,
  output logic [3:0] RANGE_O,
  output logic CONV_TIME_O,
  // open-drain interrupt pin
  output logic INT_O,
  output logic INT_OE_O,
  // software interrupt
  output logic IRQ_O
);

  // mantissa shifted by exponent gives a common lux scale
  function automatic logic [27:0] to_lux(input logic [15:0] word);
    logic [27:0] mant;
    mant = {16'h0000, word[`MANT_MSB:`MANT_LSB]};
    to_lux = mant << word[`EXP_MSB:`EXP_LSB];
  endfunction : to_lux

  // number of consecutive faults needed per code
  function automatic logic [3:0] fault_target(input logic [1:0] code);
    case (code)
      2'h0: fault_target = `FAULTS_CODE0;
      2'h1: fault_target = `FAULTS_CODE1;
      2'h2: fault_target = `FAULTS_CODE2;
      default: fault_target = `FAULTS_CODE3;
    endcase
  endfunction : fault_target

  // saturating count; restarts on a non-fault result
  function automatic logic [3:0] next_count(input logic hit, input logic [3:0] cnt);
    if (!hit) begin
      next_count = 4'h0;
    end else if (cnt >= `FAULTS_CODE3) begin
      next_count = `FAULTS_CODE3;
    end else begin
      next_count = cnt + 4'h1;
    end
  endfunction : next_count

  // configuration fields, one register each so every field has one writer
  logic [3:0] range_select_q;
  logic conv_time_q;
  light_flag_pkg::conv_mode_t mode_q;
  logic overflow_q;
  logic conversion_done_flag_q;
  logic above_limit_flag_q;
  logic below_limit_flag_q;
  logic latch_sel_q;
  logic irq_polarity_q;
  logic exponent_mask_enable_q;
  logic [1:0] fault_count_select_q;
  light_flag_pkg::cfg_t cfg_view;

  // result, limits, events and counters
  logic [15:0] result_q;
  logic [15:0] low_q;
  logic [15:0] high_q;
  logic [2:0] sts_q;
  logic [2:0] mask_q;
  logic [3:0] above_cnt_q;
  logic [3:0] below_cnt_q;
  logic [3:0] above_cnt_d;
  logic [3:0] below_cnt_d;
  logic [15:0] rdata_q;

  // decode and comparison nets
  logic wr_cfg;
  logic rd_cfg;
  logic wr_low;
  logic wr_high;
  logic wr_sts;
  logic wr_mask;
  logic done;
  logic above_hit;
  logic below_hit;
  logic above_met;
  logic below_met;
  logic above_set;
  logic below_set;
  logic int_active;
  logic [15:0] result_view;
  light_flag_pkg::cfg_t cfg_wr;
  light_flag_pkg::conv_mode_t wr_mode;

  // address decode
  assign wr_cfg = WE_I && (ADDR_I == `OFS_CONFIG);
  assign rd_cfg = RE_I && (ADDR_I == `OFS_CONFIG);
  assign wr_low = WE_I && (ADDR_I == `OFS_LOW_LIMIT);
  assign wr_high = WE_I && (ADDR_I == `OFS_HIGH_LIMIT);
  assign wr_sts = WE_I && (ADDR_I == `OFS_IRQ_STATUS);
  assign wr_mask = WE_I && (ADDR_I == `OFS_IRQ_MASK);
  assign cfg_wr = light_flag_pkg::cfg_t'(WDATA_I);
  assign wr_mode = cfg_wr.mode;
  assign done = CONV_I.done;

  // the raw result feeds the comparison, never the masked view
  assign above_hit = to_lux(CONV_I.result) > to_lux(high_q);
  assign below_hit = to_lux(CONV_I.result) < to_lux(low_q);

  // fault counters advance once per finished conversion
  always_comb begin
    above_cnt_d = above_cnt_q;
    below_cnt_d = below_cnt_q;
    if (done) begin
      above_cnt_d = next_count(above_hit, above_cnt_q);
      below_cnt_d = next_count(below_hit, below_cnt_q);
    end
  end

  // target reached on this conversion
  assign above_met = above_cnt_d >= fault_target(fault_count_select_q);
  assign below_met = below_cnt_d >= fault_target(fault_count_select_q);
  assign above_set = done && above_met;
  assign below_set = done && below_met;

  // fault counters
  // saturation at eight keeps a long fault run from wrapping to zero
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      above_cnt_q <= 4'h0;
      below_cnt_q <= 4'h0;
    end else begin
      above_cnt_q <= above_cnt_d;
      below_cnt_q <= below_cnt_d;
    end
  end

  // last conversion result and overflow
  // result is kept raw; masking happens on the read path only
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      result_q <= 16'h0000;
      overflow_q <= 1'b0;
    end else if (done) begin
      result_q <= CONV_I.result;
      overflow_q <= CONV_I.overflow;
    end
  end

  // software-written configuration fields
  // read-only bits of the written word are ignored
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      range_select_q <= `RST_RANGE;
      conv_time_q <= `RST_CONV_TIME;
      latch_sel_q <= `RST_LATCH;
      irq_polarity_q <= 1'b0;
      exponent_mask_enable_q <= 1'b0;
      fault_count_select_q <= 2'h0;
    end else if (wr_cfg) begin
      range_select_q <= cfg_wr.range_select;
      conv_time_q <= cfg_wr.conv_time;
      latch_sel_q <= cfg_wr.latch_sel;
      irq_polarity_q <= cfg_wr.irq_polarity;
      exponent_mask_enable_q <= cfg_wr.exponent_mask_enable;
      fault_count_select_q <= cfg_wr.fault_count_select;
    end
  end

  // mode; a new software command beats the single-shot return
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      mode_q <= light_flag_pkg::MODE_SHUTDOWN;
    end else if (wr_cfg) begin
      mode_q <= wr_mode;
    end else if (done && mode_q == light_flag_pkg::MODE_SINGLE) begin
      mode_q <= light_flag_pkg::MODE_SHUTDOWN;
    end
  end

  // done flag; a finishing conversion wins over a clear
  // a shutdown write keeps the flag for a later poll
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      conversion_done_flag_q <= 1'b0;
    end else if (done) begin
      conversion_done_flag_q <= 1'b1;
    end else if (rd_cfg) begin
      conversion_done_flag_q <= 1'b0;
    end else if (wr_cfg && wr_mode != light_flag_pkg::MODE_SHUTDOWN) begin
      conversion_done_flag_q <= 1'b0;
    end
  end

  // above flag: transparent tracks each result, latched holds
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      above_limit_flag_q <= 1'b0;
    end else if (!latch_sel_q) begin
      if (done) begin
        above_limit_flag_q <= above_met;
      end
    end else if (above_set) begin
      above_limit_flag_q <= 1'b1;
    end else if (rd_cfg) begin
      above_limit_flag_q <= 1'b0;
    end
  end

  // below flag: same scheme as the above flag
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      below_limit_flag_q <= 1'b0;
    end else if (!latch_sel_q) begin
      if (done) begin
        below_limit_flag_q <= below_met;
      end
    end else if (below_set) begin
      below_limit_flag_q <= 1'b1;
    end else if (rd_cfg) begin
      below_limit_flag_q <= 1'b0;
    end
  end

  // limit registers
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      low_q <= `RST_LOW_LIMIT;
      high_q <= `RST_HIGH_LIMIT;
    end else begin
      if (wr_low) begin
        low_q <= WDATA_I;
      end
      if (wr_high) begin
        high_q <= WDATA_I;
      end
    end
  end

  // sticky events, write one to clear; setting wins
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      sts_q <= 3'h0;
    end else begin
      sts_q[`IRQ_DONE_BIT] <= done |
        (sts_q[`IRQ_DONE_BIT] & ~(wr_sts & WDATA_I[`IRQ_DONE_BIT]));
      sts_q[`IRQ_ABOVE_BIT] <= above_set |
        (sts_q[`IRQ_ABOVE_BIT] & ~(wr_sts & WDATA_I[`IRQ_ABOVE_BIT]));
      sts_q[`IRQ_BELOW_BIT] <= below_set |
        (sts_q[`IRQ_BELOW_BIT] & ~(wr_sts & WDATA_I[`IRQ_BELOW_BIT]));
    end
  end

  // interrupt mask
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      mask_q <= `RST_IRQ_MASK;
    end else if (wr_mask) begin
      mask_q <= WDATA_I[2:0];
    end
  end

  // exponent hidden only in manual ranges, only on read
  always_comb begin
    result_view = result_q;
    if (exponent_mask_enable_q && range_select_q < `RANGE_AUTO) begin
      result_view[`EXP_MSB:`EXP_LSB] = 4'h0;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rdata_q <= 16'h0000;
    end else if (RE_I) begin
      case (ADDR_I)
        `OFS_RESULT: rdata_q <= result_view;
        `OFS_CONFIG: rdata_q <= cfg_view;
        `OFS_LOW_LIMIT: rdata_q <= low_q;
        `OFS_HIGH_LIMIT: rdata_q <= high_q;
        `OFS_IRQ_STATUS: rdata_q <= {13'h0000, sts_q};
        `OFS_IRQ_MASK: rdata_q <= {13'h0000, mask_q};
        default: rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  // configuration word as software reads it, bit 15 first
  always_comb begin
    cfg_view.range_select = range_select_q;
    cfg_view.conv_time = conv_time_q;
    cfg_view.mode = mode_q;
    cfg_view.overflow = overflow_q;
    cfg_view.conversion_done_flag = conversion_done_flag_q;
    cfg_view.above_limit_flag = above_limit_flag_q;
    cfg_view.below_limit_flag = below_limit_flag_q;
    cfg_view.latch_sel = latch_sel_q;
    cfg_view.irq_polarity = irq_polarity_q;
    cfg_view.exponent_mask_enable = exponent_mask_enable_q;
    cfg_view.fault_count_select = fault_count_select_q;
  end

  // pin is open drain: it only ever pulls low
  // polarity one: released while active, so the pull-up reads high
  assign int_active = above_limit_flag_q | below_limit_flag_q;
  assign INT_O = 1'b0;
  assign INT_OE_O = irq_polarity_q ? ~int_active : int_active;

  // outputs
  assign RDATA_O = rdata_q;
  assign MODE_O = mode_q;
  assign RANGE_O = range_select_q;
  assign CONV_TIME_O = conv_time_q;
  assign IRQ_O = |(sts_q & mask_q);

endmodule : light_threshold_flag_logic

`default_nettype wire

// File: light_flag_chk.sv
`timescale 1ns/10ps
`default_nettype none

module light_flag_chk (
  // clock, reset and register port
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WE_I,
  input wire logic RE_I,
  input wire logic [15:0] RDATA_O,
  // converter and pins
  input wire light_flag_pkg::conv_t CONV_I,
  input wire logic [1:0] MODE_O,
  input wire logic [3:0] RANGE_O,
  input wire logic INT_O,
  input wire logic INT_OE_O,
  input wire logic IRQ_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic me_q;
  // mask enable shadow, since only ports are visible here
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) me_q <= 1'b0;
    else if (WE_I && ADDR_I == 8'h01) me_q <= WDATA_I[2];
  end
  property p_idle;
    !RE_I |=> RDATA_O == 16'h0000;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_pin_low;
    INT_O == 1'b0;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin value not low");
  property p_done_set;
    CONV_I.done ##1 !RE_I && !WE_I ##1 RE_I && ADDR_I == 8'h01 |=> RDATA_O[7];
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");
  property p_done_clr;
    RE_I && ADDR_I == 8'h01 && !CONV_I.done ##1 !CONV_I.done ##1 RE_I && ADDR_I == 8'h01
      |=> !RDATA_O[7];
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done flag not cleared");
  property p_single;
    CONV_I.done && MODE_O == 2'h1 && !WE_I |=> MODE_O == 2'h0;
  endproperty
  a_single: assert property (p_single) else $error("single mode kept");
  property p_pol;
    $past(RE_I) && $past(ADDR_I) == 8'h01
      |-> $past(INT_OE_O) == ((RDATA_O[6] | RDATA_O[5]) ^ RDATA_O[3]);
  endproperty
  a_pol: assert property (p_pol) else $error("pin drive wrong");
  property p_irq;
    $rose(IRQ_O) |-> $past(CONV_I.done) || $past(WE_I);
  endproperty
  a_irq: assert property (p_irq) else $error("irq rose without cause");
  property p_mask;
    RE_I && ADDR_I == 8'h00 && me_q && RANGE_O < 4'hC |=> RDATA_O[15:12] == 4'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("exponent not masked");
endmodule : light_flag_chk

bind light_threshold_flag_logic light_flag_chk i_light_flag_chk (.CLK_I(CLK_I),
  .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WE_I(WE_I), .RE_I(RE_I),
  .RDATA_O(RDATA_O), .CONV_I(CONV_I), .MODE_O(MODE_O), .RANGE_O(RANGE_O), .INT_O(INT_O),
  .INT_OE_O(INT_OE_O), .IRQ_O(IRQ_O));

`default_nettype wire

// File: light_flag_host.sv
`timescale 1ns/10ps
`default_nettype none

module light_flag_host (
  // clock and read data
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  // register strobes
  output logic [7:0] addr_o,
  output logic [15:0] wdata_o,
  output logic we_o,
  output logic re_o
);
  // idle bus at time zero
  initial begin
    addr_o = 8'h00;
    wdata_o = 16'h0000;
    we_o = 1'b0;
    re_o = 1'b0;
  end
  // one-cycle write; stale data scrambled so it is never mistaken for valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    we_o <= 1'b1;
    @(posedge clk_i);
    we_o <= 1'b0;
    wdata_o <= ~d;
    #1;
  endtask : wr
  // one-cycle read; data stands only in the next cycle
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    re_o <= 1'b1;
    @(posedge clk_i);
    re_o <= 1'b0;
    #1 d = rdata_i;
  endtask : rd
endmodule : light_flag_host

`default_nettype wire

// File: light_threshold_flag_logic_bench.sv
`timescale 1ns/10ps
`default_nettype none

module light_threshold_flag_logic_bench;
  logic clk, rst_n, we, re, int_pin, int_oe, irq, ct;
  logic [7:0] addr;
  logic [15:0] wdata, rdata;
  logic [1:0] mode;
  logic [3:0] range;
  light_flag_pkg::conv_t conv;
  int fails, checked, cyc;
  // open-drain wire with its pull-up
  wire logic pin = int_oe ? int_pin : 1'b1;
  light_threshold_flag_logic i_light_threshold_flag_logic (.CLK_I(clk), .RST_N_I(rst_n),
    .ADDR_I(addr), .WDATA_I(wdata), .WE_I(we), .RE_I(re), .RDATA_O(rdata), .CONV_I(conv),
    .MODE_O(mode), .RANGE_O(range), .CONV_TIME_O(ct), .INT_O(int_pin), .INT_OE_O(int_oe),
    .IRQ_O(irq));
  light_flag_host i_light_flag_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .we_o(we), .re_o(re));
  // 50 MHz clock
  initial clk = 1'b0;
  always #10 clk = ~clk;
  // hang guard, well above the roughly 160 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] v;
    i_light_flag_host.rd(a, v);
    chk($sformatf("reg %h", a), e, v);
  endtask : rc
  task automatic w(input logic [7:0] a, input logic [15:0] d);
    i_light_flag_host.wr(a, d);
  endtask : w
  // one finished conversion; result scrambled once the pulse is gone
  task automatic cv(input logic [15:0] r);
    @(posedge clk);
    conv <= {1'b1, 1'b0, r};
    @(posedge clk);
    conv <= {1'b0, 1'b0, ~r};
    #1;
  endtask : cv
  task automatic t_reset();
    rc(8'h01, 16'h0810);
    rc(8'h02, 16'h0000);
    rc(8'h03, 16'hFFFF);
    rc(8'h05, 16'h0000);
    rc(8'h06, 16'h0000);
    rc(8'h04, 16'h0000);
    chk("irq", 16'h0000, irq);
    chk("ct", 16'h0001, ct);
    $display("reset test done");
  endtask : t_reset
  task automatic t_done();
    cv(16'h0010);
    rc(8'h01, 16'h0890);
    rc(8'h01, 16'h0810);
    cv(16'h0010);
    w(8'h01, 16'h0810);
    rc(8'h01, 16'h0890);
    cv(16'h0010);
    w(8'h01, 16'h0A10);
    rc(8'h01, 16'h0A10);
    cv(16'h0010);
    chk("mode", 16'h0000, mode);
    $display("done flag test done");
  endtask : t_done
  task automatic t_limits();
    w(8'h03, 16'h0100);
    w(8'h02, 16'h0010);
    // every fault code: one short of the count, then the count
    for (int k = 0; k < 4; k++) begin
      w(8'h01, 16'h0800 | 16'(k));
      cv(16'h0050);
      for (int n = 1; n < (1 << k); n++) cv(16'h2041);
      rc(8'h01, 16'h0880 | 16'(k));
      cv(16'h2041);
      rc(8'h01, 16'h08C0 | 16'(k));
    end
    chk("pin", 16'h0000, pin);
    cv(16'h0050);
    rc(8'h01, 16'h0883);
    w(8'h01, 16'h0801);
    cv(16'h2041);
    cv(16'h0050);
    cv(16'h2041);
    rc(8'h01, 16'h0881);
    w(8'h01, 16'h0804);
    cv(16'h1008);
    rc(8'h00, 16'h0008);
    rc(8'h01, 16'h0884);
    w(8'h01, 16'h080C);
    chk("pin", 16'h0000, pin);
    cv(16'h0008);
    chk("pin", 16'h0001, pin);
    rc(8'h01, 16'h08AC);
    w(8'h01, 16'hC804);
    cv(16'h1010);
    chk("range", 16'h000C, range);
    rc(8'h00, 16'h1010);
    $display("limit test done");
  endtask : t_limits
  task automatic t_latch();
    w(8'h01, 16'h0810);
    w(8'h05, 16'h0002);
    w(8'h04, 16'h0007);
    chk("irq", 16'h0000, irq);
    cv(16'h2041);
    chk("irq", 16'h0001, irq);
    cv(16'h0050);
    chk("pin", 16'h0000, pin);
    rc(8'h01, 16'h08D0);
    chk("pin", 16'h0001, pin);
    w(8'h05, 16'h0000);
    chk("irq", 16'h0000, irq);
    w(8'h05, 16'h0002);
    chk("irq", 16'h0001, irq);
    w(8'h04, 16'h0002);
    chk("irq", 16'h0000, irq);
    rc(8'h04, 16'h0001);
    w(8'h01, 16'h0010);
    chk("ct", 16'h0000, ct);
    $display("latch test done");
  endtask : t_latch
  // reset, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    conv = 18'h00000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_done();
    t_limits();
    t_latch();
    close_out();
  end
endmodule : light_threshold_flag_logic_bench

`default_nettype wire
